/* rtl/cache_pkg.sv */
/*
  Shared constants and state encoding for the level_one_data_cache block.
  Assumes 32-bit byte addresses and 32-bit words on every port.
*/
package cache_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;
  localparam int WAYS       = 2;
  localparam int WAY_W      = $clog2(WAYS);
  localparam int LINE_BYTES = 64;
  localparam int WORD_BYTES = DATA_W / 8;
  localparam int WORDS      = LINE_BYTES / WORD_BYTES;
  localparam int OFS_W      = $clog2(WORDS);
  localparam int BYTE_W     = $clog2(WORD_BYTES);
  localparam int LINE_W     = $clog2(LINE_BYTES);

  localparam logic [OFS_W-1:0]  BEAT_FIRST = '0;
  localparam logic [OFS_W-1:0]  BEAT_LAST  = OFS_W'(WORDS - 1);
  localparam logic [BYTE_W-1:0] BYTE_ZERO  = '0;

  // ----------------------------------------------------------------
  // Controller states, Gray coded along idle-wb-fill
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_WB   = 2'h1,
    S_FILL = 2'h3,
    S_XFER = 2'h2
  } state_t;

endpackage : cache_pkg

/* rtl/cache_way.sv */
/*
  One way of the data cache: tag, valid and dirty per set, plus line data.
  Assumes the controller gives one set index for lookup and write.
*/
module cache_way #(
  parameter int SET_W = 3,
  parameter int TAG_W = 23
) (
  input  wire logic                           mclk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           ce_i,
  input  wire logic [SET_W-1:0]               set_i,
  input  wire logic [cache_pkg::OFS_W-1:0]    word_i,
  input  wire logic [TAG_W-1:0]               tag_i,
  input  wire logic                           dat_we_i,
  input  wire logic [cache_pkg::DATA_W-1:0]   dat_i,
  input  wire logic                           tag_we_i,
  input  wire logic                           dirty_set_i,
  input  wire logic                           dirty_clr_i,
  output logic                                hit_o,
  output logic                                dirty_o,
  output logic [TAG_W-1:0]                    tag_o,
  output logic [cache_pkg::DATA_W-1:0]        data_o
);

  localparam int SETS = 1 << SET_W;

  logic [TAG_W-1:0]            tag_mem [SETS];
  logic [SETS-1:0]             valid_reg;
  logic [SETS-1:0]             dirty_reg;
  logic [cache_pkg::DATA_W-1:0] data_mem [SETS*cache_pkg::WORDS];

  // ----------------------------------------------------------------
  // Per-set tag state
  // ----------------------------------------------------------------
  for (genvar s = 0; s < SETS; s++)
  begin : g_set
    // New tag lands clean; dirty set beats dirty clear
    always_ff @(posedge mclk_i)
    begin
      if (sys_rst_i)
      begin
        valid_reg[s] <= 1'b0;
        dirty_reg[s] <= 1'b0;
        tag_mem[s]   <= '0;
      end
      else if (ce_i && set_i == SET_W'(s))
      begin
        if (tag_we_i)
        begin
          tag_mem[s]   <= tag_i;
          valid_reg[s] <= 1'b1;
          dirty_reg[s] <= 1'b0;
        end
        else if (dirty_set_i)
          dirty_reg[s] <= 1'b1;
        else if (dirty_clr_i)
          dirty_reg[s] <= 1'b0;
      end
    end
  end

  // Line data, no reset needed: valid guards it
  always_ff @(posedge mclk_i)
  begin
    if (ce_i && dat_we_i)
      data_mem[{set_i, word_i}] <= dat_i;
  end

  // Lookup
  assign hit_o   = valid_reg[set_i] && (tag_mem[set_i] == tag_i);
  assign dirty_o = valid_reg[set_i] && dirty_reg[set_i];
  assign tag_o   = tag_mem[set_i];
  assign data_o  = data_mem[{set_i, word_i}];

endmodule : cache_way

/* rtl/l1d_cache.sv */
/*
  Level-one data cache controller with victim write-back, fronting
  level_two_memory and the external_master_slave_path.
  Assumes one-word memory beats acked by mem_ack_i, and requesters that
  hold req until their one-cycle ack.
*/
module l1d_cache #(
  parameter int SET_W = 3
) (
  input  wire logic                         mclk_i,
  input  wire logic                         sys_rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         l1_ram_mode_i,
  input  wire logic                         l2_cache_mode_i,
  input  wire logic                         cpu_req_i,
  input  wire logic                         cpu_we_i,
  input  wire logic                         cpu_flush_i,
  input  wire logic [cache_pkg::ADDR_W-1:0] cpu_addr_i,
  input  wire logic [cache_pkg::DATA_W-1:0] cpu_wdata_i,
  output logic      [cache_pkg::DATA_W-1:0] cpu_rdata_o,
  output logic                              cpu_ack_o,
  input  wire logic                         dma_req_i,
  input  wire logic                         dma_we_i,
  input  wire logic [cache_pkg::ADDR_W-1:0] dma_addr_i,
  input  wire logic [cache_pkg::DATA_W-1:0] dma_wdata_i,
  output logic      [cache_pkg::DATA_W-1:0] dma_rdata_o,
  output logic                              dma_ack_o,
  output logic                              dma_err_o,
  output logic                              mem_req_o,
  output logic                              mem_we_o,
  output logic      [cache_pkg::ADDR_W-1:0] mem_addr_o,
  output logic      [cache_pkg::DATA_W-1:0] mem_wdata_o,
  input  wire logic [cache_pkg::DATA_W-1:0] mem_rdata_i,
  input  wire logic                         mem_ack_i,
  output logic                              wb_busy_o
);

  localparam int SETS  = 1 << SET_W;
  localparam int TAG_W = cache_pkg::ADDR_W - cache_pkg::LINE_W - SET_W;
  localparam int WAYS  = cache_pkg::WAYS;
  // Beat counter step at counter width, so the increment does not widen
  localparam logic [cache_pkg::OFS_W-1:0] BEAT_STEP = cache_pkg::OFS_W'(1);

  // ----------------------------------------------------------------
  // State and lookup signals
  // ----------------------------------------------------------------
  cache_pkg::state_t                state_reg;
  logic [cache_pkg::OFS_W-1:0]      beat_reg;
  logic [cache_pkg::WAY_W-1:0]      vic_reg;
  logic                             own_dma_reg;
  logic                             flush_reg;
  logic                             op_we_reg;
  logic [cache_pkg::ADDR_W-1:0]     op_addr_reg;
  logic [cache_pkg::DATA_W-1:0]     op_wdata_reg;
  logic [SETS-1:0]                  lru_reg;

  logic [cache_pkg::ADDR_W-1:0]     la;
  logic [SET_W-1:0]                 lk_set;
  logic [TAG_W-1:0]                 lk_tag;
  logic [cache_pkg::OFS_W-1:0]      lk_word;
  logic [cache_pkg::OFS_W-1:0]      rd_word;
  logic [WAYS-1:0]                  hit;
  logic [WAYS-1:0]                  dirty;
  logic [TAG_W-1:0]                 wtag [WAYS];
  logic [cache_pkg::DATA_W-1:0]     rd [WAYS];
  logic [WAYS-1:0]                  dat_we;
  logic [WAYS-1:0]                  tag_we;
  logic [WAYS-1:0]                  dset;
  logic [WAYS-1:0]                  dclr;
  logic [cache_pkg::DATA_W-1:0]     dat_val;
  logic                             hit_any;
  logic [cache_pkg::WAY_W-1:0]      hit_way;
  logic                             cached;
  logic                             dma_take;
  logic                             cpu_go;
  logic                             wr_hit;
  logic                             beat_ack;
  logic                             last_ack;
  logic                             xfer_quick;
  logic                             xfer_done;
  logic                             issue;
  logic                             vic_dirty;

  // Lookup address: live CPU address in idle, latched op otherwise
  assign la       = (state_reg == cache_pkg::S_IDLE) ? cpu_addr_i : op_addr_reg;
  assign lk_word  = la[cache_pkg::LINE_W-1:cache_pkg::BYTE_W];
  assign lk_set   = la[cache_pkg::LINE_W+SET_W-1:cache_pkg::LINE_W];
  assign lk_tag   = la[cache_pkg::ADDR_W-1:cache_pkg::LINE_W+SET_W];
  assign rd_word  = (state_reg == cache_pkg::S_WB || state_reg == cache_pkg::S_FILL)
                    ? beat_reg : lk_word;
  assign hit_any  = |hit;
  assign hit_way  = hit[1];
  assign vic_dirty = dirty[lru_reg[lk_set]];
  assign cached   = !l1_ram_mode_i;

  // Master requests win idle slots only; never during wb or fill
  assign dma_take = state_reg == cache_pkg::S_IDLE && dma_req_i && !dma_ack_o;
  assign cpu_go   = state_reg == cache_pkg::S_IDLE && !dma_take && cpu_req_i && !cpu_ack_o;
  assign wr_hit   = cpu_go && cached && cpu_we_i && !cpu_flush_i && hit_any;
  assign beat_ack = mem_req_o && mem_ack_i;
  assign last_ack = beat_ack && beat_reg == cache_pkg::BEAT_LAST;
  assign xfer_quick = own_dma_reg && (l2_cache_mode_i || (!op_we_reg && hit_any));
  assign xfer_done  = state_reg == cache_pkg::S_XFER && (xfer_quick || beat_ack);
  assign issue    = !mem_req_o && (state_reg == cache_pkg::S_WB ||
                    state_reg == cache_pkg::S_FILL ||
                    (state_reg == cache_pkg::S_XFER && !xfer_quick));

  // ----------------------------------------------------------------
  // Two ways
  // ----------------------------------------------------------------
  for (genvar w = 0; w < WAYS; w++)
  begin : g_way
    cache_way #(
      .SET_W (SET_W),
      .TAG_W (TAG_W)
    ) u_way (
      .mclk_i      (mclk_i),
      .sys_rst_i   (sys_rst_i),
      .ce_i        (ce_i),
      .set_i       (lk_set),
      .word_i      (rd_word),
      .tag_i       (lk_tag),
      .dat_we_i    (dat_we[w]),
      .dat_i       (dat_val),
      .tag_we_i    (tag_we[w]),
      .dirty_set_i (dset[w]),
      .dirty_clr_i (dclr[w]),
      .hit_o       (hit[w]),
      .dirty_o     (dirty[w]),
      .tag_o       (wtag[w]),
      .data_o      (rd[w])
    );
  end

  // Way write strobes
  always_comb
  begin
    dat_we  = '0;
    tag_we  = '0;
    dset    = '0;
    dclr    = '0;
    dat_val = cpu_wdata_i;
    if (wr_hit)
    begin
      dat_we[hit_way] = 1'b1;
      dset[hit_way]   = 1'b1;
    end
    if (state_reg == cache_pkg::S_FILL && beat_ack)
    begin
      dat_val         = mem_rdata_i;
      dat_we[vic_reg] = 1'b1;
      tag_we[vic_reg] = last_ack;
    end
    if (state_reg == cache_pkg::S_WB && last_ack)
      dclr[vic_reg] = 1'b1;
    // Snoop: master write lands in the resident copy as well
    if (state_reg == cache_pkg::S_XFER && own_dma_reg && op_we_reg && beat_ack && hit_any)
    begin
      dat_val         = op_wdata_reg;
      dat_we[hit_way] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  // Write misses bypass; read misses evict then fill
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg    <= cache_pkg::S_IDLE;
      beat_reg     <= cache_pkg::BEAT_FIRST;
      vic_reg      <= '0;
      own_dma_reg  <= 1'b0;
      flush_reg    <= 1'b0;
      op_we_reg    <= 1'b0;
      op_addr_reg  <= '0;
      op_wdata_reg <= '0;
    end
    else if (ce_i)
    begin
      unique case (state_reg)
        cache_pkg::S_IDLE:
        begin
          if (dma_take)
          begin
            own_dma_reg  <= 1'b1;
            op_addr_reg  <= dma_addr_i;
            op_we_reg    <= dma_we_i;
            op_wdata_reg <= dma_wdata_i;
            state_reg    <= cache_pkg::S_XFER;
          end
          else if (cpu_go)
          begin
            own_dma_reg  <= 1'b0;
            op_addr_reg  <= cpu_addr_i;
            op_we_reg    <= cpu_we_i;
            op_wdata_reg <= cpu_wdata_i;
            if (!cached)
              state_reg <= cache_pkg::S_XFER;
            else if (cpu_flush_i)
            begin
              if (hit_any && dirty[hit_way])
              begin
                vic_reg   <= hit_way;
                flush_reg <= 1'b1;
                state_reg <= cache_pkg::S_WB;
              end
            end
            else if (!hit_any && cpu_we_i)
              state_reg <= cache_pkg::S_XFER;
            else if (!hit_any)
            begin
              vic_reg   <= lru_reg[lk_set];
              flush_reg <= 1'b0;
              state_reg <= vic_dirty ? cache_pkg::S_WB : cache_pkg::S_FILL;
            end
          end
        end
        cache_pkg::S_WB:
        begin
          if (beat_ack)
            beat_reg <= beat_reg + BEAT_STEP;
          if (last_ack)
            state_reg <= flush_reg ? cache_pkg::S_IDLE : cache_pkg::S_FILL;
        end
        cache_pkg::S_FILL:
        begin
          if (beat_ack)
            beat_reg <= beat_reg + BEAT_STEP;
          if (last_ack)
            state_reg <= cache_pkg::S_IDLE;
        end
        cache_pkg::S_XFER:
        begin
          if (xfer_done)
            state_reg <= cache_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Replacement: the way not touched last is the next victim
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      lru_reg <= '0;
    else if (ce_i)
    begin
      if (cpu_go && cached && !cpu_flush_i && hit_any)
        lru_reg[lk_set] <= ~hit_way;
      else if (state_reg == cache_pkg::S_FILL && last_ack)
        lru_reg[lk_set] <= ~vic_reg;
    end
  end

  // ----------------------------------------------------------------
  // Memory port: one beat per req, req drops on ack
  // ----------------------------------------------------------------
  // The victim line owns the port until its last beat lands
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
    end
    else if (ce_i)
    begin
      if (beat_ack)
        mem_req_o <= 1'b0;
      else if (issue)
      begin
        mem_req_o <= 1'b1;
        unique case (state_reg)
          cache_pkg::S_WB:
          begin
            mem_we_o    <= 1'b1;
            mem_addr_o  <= {wtag[vic_reg], lk_set, beat_reg, cache_pkg::BYTE_ZERO};
            mem_wdata_o <= rd[vic_reg];
          end
          cache_pkg::S_FILL:
          begin
            mem_we_o   <= 1'b0;
            mem_addr_o <= {lk_tag, lk_set, beat_reg, cache_pkg::BYTE_ZERO};
          end
          default:
          begin
            mem_we_o    <= op_we_reg;
            mem_addr_o  <= op_addr_reg;
            mem_wdata_o <= op_wdata_reg;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cpu_ack_o   <= 1'b0;
      cpu_rdata_o <= '0;
      dma_ack_o   <= 1'b0;
      dma_err_o   <= 1'b0;
      dma_rdata_o <= '0;
      wb_busy_o   <= 1'b0;
    end
    else if (ce_i)
    begin
      cpu_ack_o <= 1'b0;
      dma_ack_o <= 1'b0;
      dma_err_o <= 1'b0;
      wb_busy_o <= state_reg == cache_pkg::S_WB;                    // One cycle late
      if (cpu_go && cached && (cpu_flush_i ? !(hit_any && dirty[hit_way]) : hit_any))
      begin
        cpu_ack_o   <= 1'b1;
        cpu_rdata_o <= rd[hit_way];
      end
      if (state_reg == cache_pkg::S_WB && last_ack && flush_reg)
        cpu_ack_o <= 1'b1;
      if (state_reg == cache_pkg::S_FILL && beat_ack && beat_reg == lk_word)
        cpu_rdata_o <= mem_rdata_i;
      if (state_reg == cache_pkg::S_FILL && last_ack)
        cpu_ack_o <= 1'b1;
      if (xfer_done && own_dma_reg)
      begin
        dma_ack_o   <= 1'b1;
        dma_err_o   <= l2_cache_mode_i;
        dma_rdata_o <= xfer_quick ? rd[hit_way] : mem_rdata_i;
      end
      else if (xfer_done)
      begin
        cpu_ack_o   <= 1'b1;
        cpu_rdata_o <= mem_rdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i iff ce_i); endclocking
  default disable iff (sys_rst_i);

  AST_ONE_WAY: assert property (!(hit[0] && hit[1]))
    else $error("line present in both ways");
  AST_WRITE_HIT_LOCAL: assert property (wr_hit |=> !mem_req_o && cpu_ack_o)
    else $error("write hit went to memory");
  AST_WRITE_NO_ALLOC: assert property (
    cpu_go && cached && cpu_we_i && !cpu_flush_i && !hit_any |=> state_reg == cache_pkg::S_XFER)
    else $error("write miss allocated");
  AST_LINE_BEATS: assert property (
    state_reg == cache_pkg::S_WB && last_ack && !flush_reg
    |=> state_reg == cache_pkg::S_FILL && beat_reg == cache_pkg::BEAT_FIRST)
    else $error("write-back not a whole line");
  AST_EVICT_FIRST: assert property (
    state_reg == cache_pkg::S_FILL && $past(state_reg) == cache_pkg::S_IDLE
    |-> !$past(vic_dirty))
    else $error("dirty victim dropped");
  AST_VICTIM_SAFE: assert property (
    state_reg == cache_pkg::S_WB && mem_req_o |-> mem_we_o && !own_dma_reg)
    else $error("victim beat interleaved");
  AST_SNOOP_WRITE: assert property (
    state_reg == cache_pkg::S_XFER && own_dma_reg && op_we_reg && beat_ack && hit_any
    |-> dat_we == hit ##1 dma_ack_o)
    else $error("master write missed cache copy");
  AST_DMA_PATH: assert property (
    dma_ack_o |-> $past(state_reg == cache_pkg::S_XFER && own_dma_reg))
    else $error("master ack outside slave path");
  AST_L2_CACHE: assert property (
    state_reg == cache_pkg::S_XFER && own_dma_reg && l2_cache_mode_i && !mem_req_o
    |=> dma_err_o && !mem_req_o)
    else $error("master reached cache-only memory");
  AST_RAM_MODE: assert property (
    state_reg == cache_pkg::S_IDLE && l1_ram_mode_i |=> state_reg != cache_pkg::S_FILL)
    else $error("allocation in ram mode");
  AST_DMA_WAITS: assert property (
    state_reg == cache_pkg::S_WB |=> !dma_ack_o)
    else $error("master served during write-back");

  COV_DIRTY_EVICT: cover property (
    state_reg == cache_pkg::S_WB && last_ack && !flush_reg ##1 state_reg == cache_pkg::S_FILL);
  COV_FLUSH: cover property (state_reg == cache_pkg::S_WB && last_ack && flush_reg);
  COV_SNOOP: cover property (dat_we != '0 && own_dma_reg && state_reg == cache_pkg::S_XFER);
  COV_DMA_WAIT: cover property (dma_req_i && state_reg == cache_pkg::S_WB);

endmodule : l1d_cache

/* bench/l2_mem_model.sv */
/*
  Behavioural level_two_memory behind the cache's memory port.
  Assumes one word beat per request, held by the cache until mem_ack_o.
*/
module l2_mem_model (
  input  wire logic        mclk_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic      [31:0] mem_rdata_o,
  output logic             mem_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [31:0] mem [1024];
  logic [3:0]  wait_reg;

  // Known pattern so fills can be predicted
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 32'h5a00_0000 | 32'(i);
    mem_ack_o   = 1'b0;
    mem_rdata_o = 32'h0;
    wait_reg    = 4'h0;
  end

  // Ack after lat_i wait cycles; data toggles off-beat so stale reads show
  always @(posedge mclk_i)
  begin
    mem_ack_o   <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i && !mem_ack_o)
    begin
      if (wait_reg >= lat_i)
      begin
        wait_reg    <= 4'h0;
        mem_ack_o   <= 1'b1;
        mem_rdata_o <= mem[mem_addr_i[11:2]];
        if (mem_we_i)
          mem[mem_addr_i[11:2]] <= mem_wdata_i;
      end
      else
        wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule : l2_mem_model

/* bench/data_cache_victim_writeback_test.sv */
/*
  Self-checking bench for the data cache with victim write-back.
  Assumes l1d_cache with 8 sets and the l2_mem_model partner.
*/
module data_cache_victim_writeback_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [31:0] PAT = 32'h5a00_0000;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
  logic        l1_ram_mode_i = 1'b0, l2_cache_mode_i = 1'b0;
  logic        cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_flush_i = 1'b0;
  logic        dma_req_i = 1'b0, dma_we_i = 1'b0;
  logic [31:0] cpu_addr_i = '0, cpu_wdata_i = '0, dma_addr_i = '0, dma_wdata_i = '0;
  logic [31:0] cpu_rdata_o, dma_rdata_o, mem_addr_o, mem_wdata_o, mem_rdata_i, rd;
  logic        cpu_ack_o, dma_ack_o, dma_err_o, mem_req_o, mem_we_o, mem_ack_i;
  logic        wb_busy_o, derr;
  logic [3:0]  lat = 4'h0;
  int          err_count = 0, compares = 0, wr_beats = 0, rd_beats = 0, w0, r0;
  int          busy_cyc = 0, b0;
  time         cpu_t, dma_t;

  always #25 mclk_i = ~mclk_i;

  l1d_cache #(.SET_W(3)) dut_u (
    .mclk_i, .sys_rst_i, .ce_i, .l1_ram_mode_i, .l2_cache_mode_i, .cpu_req_i, .cpu_we_i,
    .cpu_flush_i, .cpu_addr_i, .cpu_wdata_i, .cpu_rdata_o, .cpu_ack_o, .dma_req_i,
    .dma_we_i, .dma_addr_i, .dma_wdata_i, .dma_rdata_o, .dma_ack_o, .dma_err_o,
    .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .wb_busy_o);

  l2_mem_model mem_u (
    .mclk_i, .lat_i(lat), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
    .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
    .mem_ack_o(mem_ack_i));

  // Beat counters on the falling edge, clear of the launch edge
  always @(negedge mclk_i)
  begin
    if (wb_busy_o)
      busy_cyc++;
    if (mem_req_o && mem_ack_i)
      if (mem_we_o)
        wr_beats++;
      else
        rd_beats++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Holds the request until ack, then lets one edge pass
  task automatic cpu_op(input logic we, input logic fl, input logic [31:0] a, d);
    int n;
    n = 0;
    cpu_req_i   <= 1'b1;
    cpu_we_i    <= we;
    cpu_flush_i <= fl;
    cpu_addr_i  <= a;
    cpu_wdata_i <= d;
    @(posedge mclk_i);
    while (cpu_ack_o !== 1'b1 && n < 300)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk("cpu_ack_o", 32'h1, 32'(cpu_ack_o));
    rd = cpu_rdata_o;
    cpu_t = $time;
    cpu_req_i <= 1'b0;
    @(posedge mclk_i);
  endtask : cpu_op

  task automatic dma_op(input logic we, input logic [31:0] a, d);
    int n;
    n = 0;
    dma_req_i   <= 1'b1;
    dma_we_i    <= we;
    dma_addr_i  <= a;
    dma_wdata_i <= d;
    @(posedge mclk_i);
    while (dma_ack_o !== 1'b1 && n < 300)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk("dma_ack_o", 32'h1, 32'(dma_ack_o));
    rd = dma_rdata_o;
    derr = dma_err_o;
    dma_t = $time;
    dma_req_i <= 1'b0;
    @(posedge mclk_i);
  endtask : dma_op

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_fill_hit;
    lat <= 4'h2;
    w0 = wr_beats;
    r0 = rd_beats;
    cpu_op(1'b0, 1'b0, 32'h4, 32'h0);
    chk("fill word", PAT | 32'h1, rd);
    chk("fill beats", 32'h10, 32'(rd_beats - r0));
    cpu_op(1'b1, 1'b0, 32'h4, 32'hc0de_0001);
    cpu_op(1'b0, 1'b0, 32'h4, 32'h0);
    chk("hit word", 32'hc0de_0001, rd);
    chk("memory before evict", PAT | 32'h1, mem_u.mem[1]);
    chk("beats after hits", 32'h10, 32'(rd_beats - r0 + wr_beats - w0));
    // A write miss goes straight out and must not claim a line
    w0 = wr_beats;
    cpu_op(1'b1, 1'b0, 32'h100, 32'h7e57_0100);
    chk("write miss beats", 32'h1, 32'(wr_beats - w0));
    chk("write miss word", 32'h7e57_0100, mem_u.mem[64]);
    r0 = rd_beats;
    cpu_op(1'b0, 1'b0, 32'h100, 32'h0);
    chk("no write alloc", 32'h10, 32'(rd_beats - r0));
    chk("write miss reread", 32'h7e57_0100, rd);
  endtask : t_fill_hit

  // Explicit write-back before handing the line over
  task automatic t_flush;
    w0 = wr_beats;
    b0 = busy_cyc;
    cpu_op(1'b0, 1'b1, 32'h0, 32'h0);
    chk("flush beats", 32'h10, 32'(wr_beats - w0));
    chk("flushed word", 32'hc0de_0001, mem_u.mem[1]);
    // Busy spans 16 beats of latency 2 plus 3 handshake cycles each
    chk("wb_busy_o cycles", 32'h50, 32'(busy_cyc - b0));
    cpu_op(1'b0, 1'b1, 32'h0, 32'h0);
    chk("clean flush beats", 32'h10, 32'(wr_beats - w0));
    chk("clean flush busy", 32'h50, 32'(busy_cyc - b0));
  endtask : t_flush

  // Line-aligned buffers in set 1, slow memory, master write to the victim line requested during write-back
  task automatic t_victim;
    lat <= 4'h5;
    cpu_op(1'b0, 1'b0, 32'h40, 32'h0);
    cpu_op(1'b0, 1'b0, 32'h240, 32'h0);
    cpu_op(1'b1, 1'b0, 32'h40, 32'h1111_0040);
    cpu_op(1'b1, 1'b0, 32'h240, 32'h1111_0240);
    w0 = wr_beats;
    r0 = rd_beats;
    fork
      cpu_op(1'b0, 1'b0, 32'h440, 32'h0);
      begin
        repeat (6) @(posedge mclk_i);
        dma_op(1'b1, 32'h40, 32'hd00d_0040);
      end
    join
    chk("victim and master writes", 32'h11, 32'(wr_beats - w0));
    chk("new line fill", 32'h10, 32'(rd_beats - r0));
    chk("master after fill", 32'h1, 32'(dma_t > cpu_t));
    chk("victim word", 32'hd00d_0040, mem_u.mem[16]);
    dma_op(1'b1, 32'h444, 32'hd00d_0444);
    r0 = rd_beats;
    cpu_op(1'b0, 1'b0, 32'h444, 32'h0);
    chk("snooped word", 32'hd00d_0444, rd);
    chk("resident hit", 32'(r0), 32'(rd_beats));
    cpu_op(1'b0, 1'b0, 32'h40, 32'h0);
    chk("victim reread", 32'hd00d_0040, rd);
  endtask : t_victim

  task automatic t_modes;
    lat <= 4'h0;
    l2_cache_mode_i <= 1'b1;
    w0 = wr_beats;
    r0 = rd_beats;
    dma_op(1'b0, 32'h80, 32'h0);
    chk("dma_err_o", 32'h1, 32'(derr));
    chk("no beat", 32'h0, 32'(rd_beats - r0));
    l2_cache_mode_i <= 1'b0;
    dma_op(1'b0, 32'h84, 32'h0);
    chk("master read", PAT | 32'h21, rd);
    chk("master err", 32'h0, 32'(derr));
    l1_ram_mode_i <= 1'b1;
    r0 = rd_beats;
    cpu_op(1'b1, 1'b0, 32'h800, 32'h0bad_f00d);
    cpu_op(1'b0, 1'b0, 32'h804, 32'h0);
    chk("ram write", 32'h0bad_f00d, mem_u.mem[512]);
    chk("ram read", PAT | 32'h201, rd);
    // One beat per uncached access: one write, one read
    chk("ram beats", 32'h2, 32'(rd_beats - r0 + wr_beats - w0));
    l1_ram_mode_i <= 1'b0;
  endtask : t_modes

  task automatic finish_test;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_fill_hit();
    t_flush();
    t_victim();
    t_modes();
    finish_test();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule : data_cache_victim_writeback_test
